// File: pfc_config_master.sv
/*
 * Parallel flash configuration master: samples the mode straps when init
 * status rises, drives the flash control pins and a stepping address,
 * generates config_clock and captures bytes, then hands pins to user logic.
 * Assumes: straps and flash data are asynchronous pins; i_cfg_done comes
 * from the start-up logic on I_MCLK; pin pads combine *_OE with user drive.
 */
// Overview of operation
// - pull-ups on while pullup_disable_select is 0, until done
// - release pullup select pin once done
// - drive chip_select_out_n and config_clock during configuration
// - drive busy during configuration, user I/O afterwards
// - after done all pins but the kept top four address pins become user I/O
// - keep-host-port option keeps slave parallel port alive
// - keep-host-port keeps top four address pins
// - flash mode is m2=0, m1=1; m0 picks direction
// - sample mode straps when init status rises
// - read_write_n is an active-low write enable
// - chip enable held low during configuration
// - output enable held low during configuration
// - address steps on each config_clock falling edge
// - data byte captured on config_clock rising edge
// - write enable held high during configuration
// - byte mode held low during configuration
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"

module pfc_config_master #(
    parameter int ADDR_W   = `PFC_ADDR_W,
    parameter int HALF_CYC = `PFC_CONFIG_CLOCK_HALF_CYC
) (
    // clock and reset
    input  wire logic                     I_MCLK,
    input  wire logic                     I_RST_B,
    // status from start-up sequencing
    input  wire logic                     i_INIT_DONE,
    input  wire logic                     i_CFG_DONE,
    input  wire logic                     i_KEEP_HOST_PORT,
    // strap and host pins
    input  wire logic                     i_PULLUP_DISABLE_SELECT,
    input  wire logic [2:0]               i_MODE,
    input  wire logic                     i_CHIP_SELECT_N,
    input  wire logic                     i_READ_WRITE_N,
    // flash data pins
    input  wire logic [`PFC_DATA_W-1:0]   i_FLASH_DATA,
    // flash pins
    output logic [ADDR_W-1:0]             o_FLASH_ADDR,
    output logic [ADDR_W-1:0]             o_FLASH_ADDR_OE,
    output pfc_pkg::pfc_prom_ctrl_s       o_PROM_CTRL,
    output logic                          o_PROM_CTRL_OE,
    output logic                          o_CONFIG_CLOCK,
    output logic                          o_CHIP_SELECT_OUT_N,
    output logic                          o_BUSY,
    output logic                          o_CFG_PINS_OE,
    // toward the loader and user side
    output logic [`PFC_DATA_W-1:0]        o_BYTE,
    output logic                          o_BYTE_VALID,
    output logic                          o_MODE_OK,
    output logic                          o_PULLUP_EN,
    output logic                          o_PULLUP_PIN_USER,
    output logic                          o_HOST_PORT_ACTIVE,
    output logic                          o_HOST_WRITE,
    output logic                          o_STRAP_FAULT
);

    // the synced byte needs four edges after a step, so shorter half periods
    // would capture the previous address's byte
    if (ADDR_W < `PFC_HIGH_ADDR_LSB + 1 || ADDR_W > `PFC_ADDR_W ||
        HALF_CYC < 4 || HALF_CYC > 65536) begin : g_bad_param
        $error("pfc_config_master: unsupported parameters");
    end

    // three-stage sync; first stage feeds only the second
    logic [2:0] mode_s1_r, mode_s2_r, mode_s3_r;
    logic [2:0] ctl_s1_r, ctl_s2_r, ctl_s3_r;
    logic [7:0] dat_s1_r, dat_s2_r, dat_s3_r;
    logic [2:0] mode_q_r, ctl_q_r;
    logic [7:0] dat_q_r;

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode_s1_r <= 3'h0; mode_s2_r <= 3'h0; mode_s3_r <= 3'h0;
            ctl_s1_r  <= 3'h0; ctl_s2_r  <= 3'h0; ctl_s3_r  <= 3'h0;
            dat_s1_r  <= 8'h0; dat_s2_r  <= 8'h0; dat_s3_r  <= 8'h0;
            mode_q_r  <= 3'h0; ctl_q_r   <= 3'h0; dat_q_r   <= 8'h0;
        end else begin
            mode_s1_r <= i_MODE;
            mode_s2_r <= mode_s1_r;
            mode_s3_r <= mode_s2_r;
            ctl_s1_r  <= {i_PULLUP_DISABLE_SELECT, i_CHIP_SELECT_N, i_READ_WRITE_N};
            ctl_s2_r  <= ctl_s1_r;
            ctl_s3_r  <= ctl_s2_r;
            dat_s1_r  <= i_FLASH_DATA;
            dat_s2_r  <= dat_s1_r;
            dat_s3_r  <= dat_s2_r;
            if (mode_s2_r == mode_s3_r)
                mode_q_r <= mode_s2_r;
            if (ctl_s2_r == ctl_s3_r)
                ctl_q_r <= ctl_s2_r;
            if (dat_s2_r == dat_s3_r)
                dat_q_r <= dat_s2_r;
        end
    end

    wire pullup_sel = ctl_q_r[2];
    wire cs_n       = ctl_q_r[1];
    wire rdwr_n     = ctl_q_r[0];
    // agreed byte one edge before dat_q_r shows it; keeps capture on the
    // address stepped half a config_clock period earlier
    wire [7:0] dat_filt = (dat_s2_r == dat_s3_r) ? dat_s2_r : dat_q_r;

    pfc_pkg::pfc_state_e state_r, state_nxt;
    pfc_pkg::pfc_mode_s  mode_r;
    logic                init_d_r;
    logic [ADDR_W-1:0]   addr_r;
    logic [15:0]         div_r;
    logic                config_clock_r;
    logic                pu_sel_r;

    wire init_rise = i_INIT_DONE && !init_d_r;
    wire flash_mode = (mode_q_r[2] == `PFC_MODE_FLASH_M2) &&
                      (mode_q_r[1] == `PFC_MODE_FLASH_M1);
    wire loading   = (state_r == pfc_pkg::PFC_LOAD);
    wire done      = (state_r == pfc_pkg::PFC_DONE);
    wire div_end   = (div_r == 16'(HALF_CYC - 1));
    wire config_clock_fall = loading && div_end && config_clock_r;
    wire config_clock_rise = loading && div_end && !config_clock_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pfc_pkg::PFC_IDLE:  if (init_rise) state_nxt = flash_mode ?
                                    pfc_pkg::PFC_LOAD : pfc_pkg::PFC_ARMED;
            pfc_pkg::PFC_ARMED: if (i_CFG_DONE) state_nxt = pfc_pkg::PFC_DONE;
            pfc_pkg::PFC_LOAD:  if (i_CFG_DONE) state_nxt = pfc_pkg::PFC_DONE;
            pfc_pkg::PFC_DONE:  state_nxt = pfc_pkg::PFC_DONE;
            default:            state_nxt = pfc_pkg::PFC_IDLE;
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_r  <= pfc_pkg::PFC_IDLE;
            init_d_r <= 1'b0;
            mode_r   <= '0;
            pu_sel_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            init_d_r <= i_INIT_DONE;
            if (init_rise) begin
                mode_r   <= mode_q_r;
                pu_sel_r <= pullup_sel;
            end
        end
    end

    // config_clock divider and address stepping
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            div_r  <= 16'h0000;
            config_clock_r <= 1'b0;
            addr_r <= '0;
        end else begin
            if (init_rise)
                addr_r <= (mode_q_r[0] == `PFC_DIR_UP) ?
                          ADDR_W'(`PFC_ADDR_UP_START) : ADDR_W'(`PFC_ADDR_DN_START);
            else if (config_clock_fall)
                addr_r <= (mode_r.address_direction_select == `PFC_DIR_UP) ?
                          addr_r + 1'b1 : addr_r - 1'b1;
            if (loading) begin
                div_r <= div_end ? 16'h0000 : div_r + 16'h0001;
                if (div_end)
                    config_clock_r <= !config_clock_r;
            end else begin
                div_r  <= 16'h0000;
                config_clock_r <= 1'b0;
            end
        end
    end

    // byte capture on rising config_clock edge
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            o_BYTE       <= 8'h00;
            o_BYTE_VALID <= 1'b0;
        end else begin
            o_BYTE_VALID <= config_clock_rise;
            if (config_clock_rise)
                o_BYTE <= dat_filt;
        end
    end

    // straps sampled above; board keeps them still while loading
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B)
            o_STRAP_FAULT <= 1'b0;
        else if (loading && (pullup_sel != pu_sel_r || cs_n || rdwr_n))
            o_STRAP_FAULT <= 1'b1;
    end

    wire cfg_active = !done;
    wire keep_host  = done && i_KEEP_HOST_PORT;

    assign o_FLASH_ADDR    = addr_r;
    // top four address pins stay with configuration under keep-host-port
    genvar g;
    generate
        for (g = 0; g < ADDR_W; g++) begin : g_aoe
            if (g >= `PFC_HIGH_ADDR_LSB)
                assign o_FLASH_ADDR_OE[g] = cfg_active || keep_host;
            else
                assign o_FLASH_ADDR_OE[g] = cfg_active;
        end
    endgenerate

    assign o_PROM_CTRL.chip_enable_n   = `PFC_CTRL_IDLE_LOW;
    assign o_PROM_CTRL.output_enable_n = `PFC_CTRL_IDLE_LOW;
    assign o_PROM_CTRL.byte_mode_n     = `PFC_CTRL_IDLE_LOW;
    assign o_PROM_CTRL.write_enable_n  = `PFC_CTRL_IDLE_HIGH;
    assign o_PROM_CTRL_OE      = cfg_active;
    assign o_CONFIG_CLOCK      = config_clock_r;
    assign o_CHIP_SELECT_OUT_N = 1'b1;
    assign o_BUSY              = 1'b0;
    assign o_CFG_PINS_OE       = cfg_active;
    assign o_MODE_OK           = flash_mode;
    assign o_PULLUP_EN         = cfg_active && !pullup_sel;
    assign o_PULLUP_PIN_USER   = done;
    assign o_HOST_PORT_ACTIVE  = keep_host;
    assign o_HOST_WRITE        = keep_host && !cs_n && !rdwr_n;

endmodule

`default_nettype wire

// File: pfc_defines.svh
/*
 * Constants for the parallel flash configuration master: mode codes,
 * address start values, clock divider and control-pin levels.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_ADDR_W          24
`define PFC_DATA_W          8
`define PFC_ADDR_UP_START   24'h000000
`define PFC_ADDR_DN_START   24'hFFFFFF
`define PFC_MODE_FLASH_M2   1'b0
`define PFC_MODE_FLASH_M1   1'b1
`define PFC_DIR_UP          1'b0
`define PFC_CONFIG_CLOCK_HALF_NS    40
`define PFC_CLK_PERIOD_NS   10
`define PFC_CONFIG_CLOCK_HALF_CYC   (`PFC_CONFIG_CLOCK_HALF_NS / `PFC_CLK_PERIOD_NS)
`define PFC_HIGH_ADDR_LSB   20
`define PFC_CTRL_IDLE_LOW   1'b0
`define PFC_CTRL_IDLE_HIGH  1'b1

`endif

// File: pfc_pkg.sv
/*
 * Types for the parallel flash configuration master.
 * Assumes pfc_defines.svh is on the include path.
 */
`include "pfc_defines.svh"

package pfc_pkg;

    typedef enum logic [3:0] {
        PFC_IDLE  = 4'b0001,
        PFC_ARMED = 4'b0010,
        PFC_LOAD  = 4'b0100,
        PFC_DONE  = 4'b1000
    } pfc_state_e;

    // flash control pins, all active low
    typedef struct packed {
        logic chip_enable_n;
        logic output_enable_n;
        logic byte_mode_n;
        logic write_enable_n;
    } pfc_prom_ctrl_s;

    // captured mode straps
    typedef struct packed {
        logic m2;
        logic m1;
        logic address_direction_select;
    } pfc_mode_s;

endpackage

// File: pfc_chk_sva.sv
/* port checker for pfc_config_master
   assumes HALF_CYC of 4 and that the done input rises only while loading */
`timescale 1ns/1ps
`default_nettype none
module pfc_chk_sva #(
    parameter int ADDR_W = 24
) (
    input wire logic I_MCLK, I_RST_B, i_CFG_DONE, i_KEEP_HOST_PORT,
    input wire logic i_PULLUP_DISABLE_SELECT, o_PROM_CTRL_OE, o_CONFIG_CLOCK,
    input wire logic o_CHIP_SELECT_OUT_N, o_CFG_PINS_OE, o_BYTE_VALID,
    input wire logic o_MODE_OK, o_PULLUP_EN, o_PULLUP_PIN_USER,
    input wire logic [2:0] i_MODE,
    input wire logic [ADDR_W-1:0] o_FLASH_ADDR, o_FLASH_ADDR_OE,
    input wire pfc_pkg::pfc_prom_ctrl_s o_PROM_CTRL
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    logic [ADDR_W-1:0] keep_oe;
    assign keep_oe = {{4{i_KEEP_HOST_PORT}}, {(ADDR_W-4){1'b0}}};
    pullup_follow_a: assert property (
        $stable(i_PULLUP_DISABLE_SELECT)[*6] ##0 !o_PULLUP_PIN_USER
        |-> o_PULLUP_EN == !i_PULLUP_DISABLE_SELECT) else $error("pull-up enable wrong");
    pin_release_a: assert property (
        i_CFG_DONE |=> o_PULLUP_PIN_USER && !o_PULLUP_EN && !o_CFG_PINS_OE
        && !o_PROM_CTRL_OE) else $error("pins not released");
    ctrl_level_a: assert property (
        !o_PULLUP_PIN_USER |-> o_PROM_CTRL_OE && o_PROM_CTRL == 4'h1)
        else $error("flash control level wrong");
    cfg_drive_a: assert property (
        !o_PULLUP_PIN_USER |-> o_CFG_PINS_OE && &o_FLASH_ADDR_OE && o_CHIP_SELECT_OUT_N)
        else $error("config pins not driven");
    host_addr_a: assert property (
        o_PULLUP_PIN_USER |-> o_FLASH_ADDR_OE == keep_oe) else $error("address enable wrong");
    addr_step_a: assert property (
        $fell(o_CONFIG_CLOCK) && !o_PULLUP_PIN_USER |-> o_FLASH_ADDR == $past(o_FLASH_ADDR)
        + 1'b1 || o_FLASH_ADDR == $past(o_FLASH_ADDR) - 1'b1) else $error("bad step");
    addr_hold_a: assert property (
        o_CONFIG_CLOCK |-> $stable(o_FLASH_ADDR)) else $error("address moved");
    half_period_a: assert property (
        $changed(o_CONFIG_CLOCK) |=> ($stable(o_CONFIG_CLOCK) || o_PULLUP_PIN_USER)[*3]
        ##1 ($changed(o_CONFIG_CLOCK) || o_PULLUP_PIN_USER)) else $error("clock period");
    byte_take_a: assert property (
        $rose(o_CONFIG_CLOCK) && !o_PULLUP_PIN_USER |-> ##[0:1] o_BYTE_VALID)
        else $error("no capture");
    mode_dec_a: assert property (
        $stable(i_MODE)[*5] |-> o_MODE_OK == (i_MODE[2:1] == 2'b01)) else $error("mode");
endmodule
bind pfc_config_master pfc_chk_sva #(.ADDR_W(ADDR_W)) i_sva (.*);
`default_nettype wire

// File: pfc_flash_model.sv
/* parallel flash model: byte pattern of the address
   assumes pads drive only while the master enables them */
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model (
    input  wire logic [23:0]            i_addr,
    input  wire pfc_pkg::pfc_prom_ctrl_s i_ctrl,
    input  wire logic                   i_oe,
    output logic [7:0]                  o_data
);
    wire sel = i_oe && !i_ctrl.chip_enable_n && !i_ctrl.output_enable_n;
    wire [7:0] mem = i_addr[7:0] ^ i_addr[23:16] ^ 8'h5A;
    // released bus shows the inverse, never a stale match
    assign o_data = sel ? mem : ~mem;
endmodule
`default_nettype wire

// File: tb_top.sv
/* bench for pfc_config_master
   assumes the flash model on the far side and HALF_CYC of 4 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst_b, init_done, cfg_done, keep_host, pu_sel, cs_n, rw_n;
    logic [2:0] mode;
    wire [7:0] fdata, byte_q;
    wire [23:0] addr, addr_oe;
    pfc_pkg::pfc_prom_ctrl_s ctrl;
    wire ctrl_oe, config_clock, cs_out_n, busy, pins_oe, bvalid, mode_ok;
    wire pu_en, pu_user, host_act, host_wr, fault;
    int err_count, total_checks, cyc;
    pfc_config_master i_dut (.I_MCLK(clk), .I_RST_B(rst_b), .i_INIT_DONE(init_done),
        .i_CFG_DONE(cfg_done), .i_KEEP_HOST_PORT(keep_host), .i_MODE(mode),
        .i_PULLUP_DISABLE_SELECT(pu_sel), .i_CHIP_SELECT_N(cs_n), .i_READ_WRITE_N(rw_n),
        .i_FLASH_DATA(fdata), .o_FLASH_ADDR(addr), .o_FLASH_ADDR_OE(addr_oe),
        .o_PROM_CTRL(ctrl), .o_PROM_CTRL_OE(ctrl_oe), .o_CONFIG_CLOCK(config_clock),
        .o_CHIP_SELECT_OUT_N(cs_out_n), .o_BUSY(busy), .o_CFG_PINS_OE(pins_oe),
        .o_BYTE(byte_q), .o_BYTE_VALID(bvalid), .o_MODE_OK(mode_ok), .o_PULLUP_EN(pu_en),
        .o_PULLUP_PIN_USER(pu_user), .o_HOST_PORT_ACTIVE(host_act),
        .o_HOST_WRITE(host_wr), .o_STRAP_FAULT(fault));
    pfc_flash_model i_flash (.i_addr(addr), .i_ctrl(ctrl), .i_oe(ctrl_oe), .o_data(fdata));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] m, input logic pu, input logic kh);
        @(negedge clk);
        rst_b = 0;
        init_done = 0;
        cfg_done = 0;
        cs_n = 0;
        rw_n = 0;
        mode = m;
        pu_sel = pu;
        keep_host = kh;
        repeat (2) @(negedge clk);
        rst_b = 1;
        repeat (6) @(negedge clk);
    endtask
    task automatic run_load(input logic [2:0] m, input logic pu, input logic kh);
        logic [23:0] a0;
        logic [23:0] ea;
        do_reset(m, pu, kh);
        a0 = m[0] ? 24'hFFFFFF : 24'h000000;
        check(pu_en, !pu);
        init_done = 1;
        repeat (2) @(negedge clk);
        check(addr, a0);
        check(ctrl, 4'h1);
        check({busy, cs_out_n, pins_oe}, 3'b011);
        for (int k = 0; k < 5; k++) begin
            @(posedge bvalid);
            @(negedge clk);
            ea = m[0] ? a0 - 24'(k) : a0 + 24'(k);
            check(addr, ea);
            check(byte_q, ea[7:0] ^ ea[23:16] ^ 8'h5A);
        end
        check(fault, 0);
        cfg_done = 1;
        repeat (2) @(negedge clk);
        check(pu_user, 1);
        check(addr_oe, kh ? 24'hF00000 : 24'h0);
        check({pins_oe, ctrl_oe}, 0);
        check(host_act, kh);
        check(host_wr, kh);
        rw_n = 1;
        repeat (6) @(negedge clk);
        check(host_wr, 0);
        rw_n = 0;
    endtask
    task automatic mode_scan;
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            repeat (6) @(negedge clk);
            check(mode_ok, m[2:1] == 2'b01);
        end
        do_reset(3'b100, 1'b0, 1'b0);
        init_done = 1;
        repeat (30) @(negedge clk);
        check({config_clock, addr}, 0);
    endtask
    task automatic strap_move;
        do_reset(3'b010, 1'b0, 1'b0);
        init_done = 1;
        repeat (4) @(negedge clk);
        mode = 3'b011;
        pu_sel = 1;
        repeat (40) @(negedge clk);
        check(addr < 24'h10, 1);
        check(fault, 1);
    endtask
    initial begin
        {rst_b, init_done, cfg_done, keep_host, pu_sel, cs_n, rw_n, mode} = '0;
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        run_load(3'b010, 1'b0, 1'b0);
        run_load(3'b011, 1'b1, 1'b1);
        mode_scan();
        strap_move();
        complete_run();
    end
endmodule
`default_nettype wire
